// ==== verilog/cbus_pkg.sv ====
// constants and types for the capacitor bank unbalance stage
package cbus_pkg;
  // register byte offsets
  localparam logic [7:0] REG_MODE       = 8'h00;
  localparam logic [7:0] REG_CMD        = 8'h04;
  localparam logic [7:0] REG_ALM_PICKUP = 8'h08;
  localparam logic [7:0] REG_LOC_PICKUP = 8'h0c;
  localparam logic [7:0] REG_ALM_TIME   = 8'h10;
  localparam logic [7:0] REG_LOC_TIME   = 8'h14;
  localparam logic [7:0] REG_ALLOWED    = 8'h18;
  localparam logic [7:0] REG_EVENT_EN   = 8'h1c;
  localparam logic [7:0] REG_STATUS     = 8'h20;
  localparam logic [7:0] REG_RAW        = 8'h24;
  localparam logic [7:0] REG_ALM_COMP   = 8'h28;
  localparam logic [7:0] REG_LOC_COMP   = 8'h2c;
  localparam logic [7:0] REG_ALM_REF    = 8'h30;
  localparam logic [7:0] REG_LOC_REF    = 8'h34;
  localparam logic [7:0] REG_CHANGE     = 8'h38;
  localparam logic [7:0] REG_CHANGE_MAG = 8'h3c;
  localparam logic [7:0] REG_ALM_REF_MAG = 8'h40;
  localparam logic [7:0] REG_LOC_REF_MAG = 8'h44;
  localparam logic [7:0] REG_CNT_LOW    = 8'h48;
  localparam logic [7:0] REG_CNT_HIGH   = 8'h4c;
  localparam logic [7:0] REG_ALM_COUNTS = 8'h50;
  localparam logic [7:0] REG_LOC_COUNTS = 8'h54;
  localparam logic [7:0] REG_ALM_FAULT  = 8'h58;
  localparam logic [7:0] REG_LOC_FAULT  = 8'h5c;
  localparam logic [7:0] REG_LAST       = 8'h5c;
  // field positions
  localparam int MODE_ALM_COMP_BIT = 0;
  localparam int MODE_LOC_LSB      = 4;
  localparam int MODE_SEL_LSB      = 8;
  localparam int CMD_CAPTURE_BIT   = 0;
  localparam int CMD_CLEAR_BIT     = 1;
  localparam int FAULT_PCT_LSB     = 24;
  // modes
  typedef enum logic [1:0] {CBUS_LOC_OFF, CBUS_LOC_NORMAL, CBUS_LOC_LOCATE} cbus_loc_mode_t;
  typedef enum logic [1:0] {CBUS_SEL_ONE, CBUS_SEL_TWO, CBUS_SEL_DERIVED} cbus_sel_t;
  // reset values and setting limits (pickup in 0.01 pu, time in 10 ms)
  localparam logic [10:0] ALM_PICKUP_RST = 11'h00a;
  localparam logic [10:0] LOC_PICKUP_RST = 11'h014;
  localparam logic [10:0] PICKUP_MIN     = 11'h001;
  localparam logic [10:0] PICKUP_MAX     = 11'h7d0;
  localparam logic [14:0] ALM_TIME_RST   = 15'h0032;
  localparam logic [14:0] LOC_TIME_RST   = 15'h0064;
  localparam logic [14:0] TIME_MIN       = 15'h0008;
  localparam logic [14:0] TIME_MAX       = 15'h7530;
  localparam logic [7:0]  ALLOWED_RST    = 8'h03;
  localparam logic [3:0]  EVENT_EN_RST   = 4'hf;
  // phasor lsb is 0.001 pu, setting lsb 0.01 pu
  localparam logic [3:0]  PU_SCALE       = 4'ha;
  localparam logic [15:0] PCT_FULL       = 16'h0064;
  localparam logic [15:0] TAN30_Q15      = 16'h49e7;
  // timing
  localparam int CLK_MHZ          = 200;
  localparam int TIME_BASE_US     = 10000;
  localparam int TIME_BASE_CYCLES = TIME_BASE_US * CLK_MHZ;
  // angle sector (0 deg, 60, 120 ...) to branch counter index
  localparam logic [2:0] SECTOR_TO_COUNTER [6] = '{3'h0, 3'h3, 3'h4, 3'h1, 3'h2, 3'h5};
endpackage

// ==== verilog/cbus_stage.sv ====
// capacitor bank unbalance alarm and locating stages with apb registers
//
// Behaviour
// - capture command stores present unbalance phasor relative to L1 as reference.
// - alarm reference captured only on command; alarm stage never captures by itself.
// - unbalance angle expressed relative to the L1 current angle.
// - compensated current is measured phasor minus stored reference.
// - compensated magnitude compared to pickup, 0.01-20.00 pu, defaults 0.10/0.20.
// - definite time 0.08-300.00 s per stage, defaults 0.50/1.00 s.
// - in location mode the locating stage re-captures its reference instead of tripping on time.
// - locating re-capture leaves alarm reference and compensated current alone.
// - change angle selects one of six branch/phase counters to increment.
// - locating trip when confirmed failures exceed the allowed count.
// - readable running total of confirmed element failures.
// - clear command zeroes six counters and the total.
// - alarm comp off/on; locating off/normal/location, counting only in location.
// - raw and compensated unbalance readable.
// - stored reference components and magnitude readable after capture.
// - unbalance change recorded just before each automatic re-capture.
// - per stage largest fault value and elapsed time percent recorded.
`timescale 1ns/10ps
module cbus_stage
  import cbus_pkg::*;
#(
  parameter int unsigned TIME_BASE_CYCLES_P = TIME_BASE_CYCLES
) (
  // clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               srst_in,
  // apb slave
  input  wire logic [7:0]         paddr_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [31:0]        pwdata_in,
  output logic      [31:0]        prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  // phasor measurements
  input  wire logic               meas_tick_in,
  input  wire logic signed [15:0] residual_input_one_re_in,
  input  wire logic signed [15:0] residual_input_one_im_in,
  input  wire logic signed [15:0] residual_input_two_re_in,
  input  wire logic signed [15:0] residual_input_two_im_in,
  input  wire logic signed [15:0] derived_residual_sum_re_in,
  input  wire logic signed [15:0] derived_residual_sum_im_in,
  input  wire logic signed [15:0] l1_cos_in,
  input  wire logic signed [15:0] l1_sin_in,
  // stage outputs
  output logic                    alarm_start_out,
  output logic                    alarm_trip_out,
  output logic                    loc_start_out,
  output logic                    loc_trip_out,
  output logic      [7:0]         event_out
);
  if (TIME_BASE_CYCLES_P < 2 || TIME_BASE_CYCLES_P > 4194304) begin : g_bad_time_base
    $error("time base cycle count out of range");
  end
  typedef struct packed {
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic                        alm_comp_on;
    cbus_loc_mode_t              loc_mode;
    cbus_sel_t                   sel;
    logic [1:0][10:0]            pickup;
    logic [1:0][14:0]            optime;
    logic [7:0]                  allowed;
    logic [1:0][3:0]             ev_en;
    logic [1:0][15:0]            ref_re;
    logic [1:0][15:0]            ref_im;
    logic signed [16:0]          chg_re;
    logic signed [16:0]          chg_im;
    logic [5:0][7:0]             branch_cnt;
    logic [7:0]                  total;
    logic [1:0]                  start;
    logic [1:0]                  trip;
    logic [1:0][14:0]            acc;
    logic [1:0][15:0]            rem;
    logic [1:0][15:0]            pct;
    logic [1:0][7:0]             elapsed_operate_percent;
    logic [1:0][16:0]            fit;
    logic [1:0][15:0]            scnt;
    logic [1:0][15:0]            tcnt;
    logic [7:0]                  events;
    logic [21:0]                 div;
    logic                        tick10;
  } cbus_state_t;
  cbus_state_t s;
  cbus_state_t next_s;
  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) return 16'sh7fff;
    if (v < -34'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction
  // cheap magnitude: max + min/2, within about 12 percent
  function automatic logic [16:0] mag_approx(input logic signed [16:0] re,
                                             input logic signed [16:0] im);
    logic [16:0] a;
    logic [16:0] b;
    a = re[16] ? 17'(-re) : 17'(re);
    b = im[16] ? 17'(-im) : 17'(im);
    return (a > b) ? 17'(a + (b >> 1)) : 17'(b + (a >> 1));
  endfunction
  function automatic logic [31:0] pack2(input logic signed [16:0] re,
                                        input logic signed [16:0] im);
    return {sat16(34'(im)), sat16(34'(re))};
  endfunction
  logic signed [15:0] unb_re;
  logic signed [15:0] unb_im;
  logic signed [15:0] rel_re;
  logic signed [15:0] rel_im;
  logic signed [16:0] comp_re [2];
  logic signed [16:0] comp_im [2];
  logic               pick    [2];
  logic [2:0]         sector;

  always_comb begin
    logic signed [33:0] pr;
    logic signed [33:0] pi;
    logic [34:0]        msq;
    logic [14:0]        thr;
    logic [16:0]        are;
    logic [16:0]        aim;
    logic [32:0]        lim;
    pr = '0;
    pi = '0;
    msq = '0;
    thr = '0;
    are = '0;
    aim = '0;
    lim = '0;
    unique case (s.sel)
      CBUS_SEL_ONE: begin
        unb_re = residual_input_one_re_in;
        unb_im = residual_input_one_im_in;
      end
      CBUS_SEL_TWO: begin
        unb_re = residual_input_two_re_in;
        unb_im = residual_input_two_im_in;
      end
      default: begin
        unb_re = derived_residual_sum_re_in;
        unb_im = derived_residual_sum_im_in;
      end
    endcase
    // rotate by minus the L1 angle so frequency drift cancels
    pr = 34'(unb_re * l1_cos_in) + 34'(unb_im * l1_sin_in);
    pi = 34'(unb_im * l1_cos_in) - 34'(unb_re * l1_sin_in);
    rel_re = sat16(pr >>> 15);
    rel_im = sat16(pi >>> 15);
    for (int i = 0; i < 2; i++) begin
      if (i == 0 ? s.alm_comp_on : (s.loc_mode != CBUS_LOC_OFF)) begin
        comp_re[i] = 17'(rel_re) - 17'(signed'(s.ref_re[i]));
        comp_im[i] = 17'(rel_im) - 17'(signed'(s.ref_im[i]));
      end else begin
        comp_re[i] = 17'(rel_re);
        comp_im[i] = 17'(rel_im);
      end
      msq = 35'(comp_re[i] * comp_re[i]) + 35'(comp_im[i] * comp_im[i]);
      thr = 15'(s.pickup[i] * PU_SCALE);
      pick[i] = msq > 35'(thr * thr);
    end
    // sectors of 60 degrees centred on 0, 60, 120 ... relative to L1
    are = comp_re[1][16] ? 17'(-comp_re[1]) : 17'(comp_re[1]);
    aim = comp_im[1][16] ? 17'(-comp_im[1]) : 17'(comp_im[1]);
    lim = 33'(are * TAN30_Q15);
    if ({aim, 15'h0000} < 32'(lim)) begin
      sector = comp_re[1][16] ? 3'h3 : 3'h0;
    end else if (!comp_im[1][16]) begin
      sector = comp_re[1][16] ? 3'h2 : 3'h1;
    end else begin
      sector = comp_re[1][16] ? 3'h4 : 3'h5;
    end
  end

  logic [31:0] rd;
  logic        hit;

  always_comb begin
    hit = (paddr_in[1:0] == 2'h0) && (paddr_in <= REG_LAST);
    rd = '0;
    unique case (paddr_in)
      REG_MODE: rd = {22'h0, s.sel, 2'h0, s.loc_mode, 3'h0, s.alm_comp_on};
      REG_ALM_PICKUP: rd = {21'h0, s.pickup[0]};
      REG_LOC_PICKUP: rd = {21'h0, s.pickup[1]};
      REG_ALM_TIME: rd = {17'h0, s.optime[0]};
      REG_LOC_TIME: rd = {17'h0, s.optime[1]};
      REG_ALLOWED: rd = {24'h0, s.allowed};
      REG_EVENT_EN: rd = {24'h0, s.ev_en};
      REG_STATUS: rd = {16'h0, s.total, 4'h0, s.trip, s.start};
      REG_RAW: rd = {rel_im, rel_re};
      REG_ALM_COMP: rd = pack2(comp_re[0], comp_im[0]);
      REG_LOC_COMP: rd = pack2(comp_re[1], comp_im[1]);
      REG_ALM_REF: rd = {s.ref_im[0], s.ref_re[0]};
      REG_LOC_REF: rd = {s.ref_im[1], s.ref_re[1]};
      REG_CHANGE: rd = pack2(s.chg_re, s.chg_im);
      REG_CHANGE_MAG: rd = {15'h0, mag_approx(s.chg_re, s.chg_im)};
      REG_ALM_REF_MAG: rd = {15'h0, mag_approx(17'(signed'(s.ref_re[0])),
                                               17'(signed'(s.ref_im[0])))};
      REG_LOC_REF_MAG: rd = {15'h0, mag_approx(17'(signed'(s.ref_re[1])),
                                               17'(signed'(s.ref_im[1])))};
      REG_CNT_LOW: rd = s.branch_cnt[3:0];
      REG_CNT_HIGH: rd = {16'h0, s.branch_cnt[5:4]};
      REG_ALM_COUNTS: rd = {s.tcnt[0], s.scnt[0]};
      REG_LOC_COUNTS: rd = {s.tcnt[1], s.scnt[1]};
      REG_ALM_FAULT: rd = {s.elapsed_operate_percent[0], 7'h0, s.fit[0]};
      REG_LOC_FAULT: rd = {s.elapsed_operate_percent[1], 7'h0, s.fit[1]};
      default: rd = '0;
    endcase
  end

  always_comb begin
    logic       wr;
    logic       capture;
    logic       clear;
    logic       locate;
    logic [2:0] idx;
    logic [16:0] m;
    next_s = s;
    wr = 1'b0;
    capture = 1'b0;
    clear = 1'b0;
    locate = 1'b0;
    idx = '0;
    m = '0;
    next_s.events = '0;
    // time base divider
    next_s.tick10 = (s.div == 22'(TIME_BASE_CYCLES_P - 1));
    next_s.div = next_s.tick10 ? '0 : 22'(s.div + 22'h1);
    // apb: one wait state, write lands on the completing edge
    next_s.pready = psel_in && penable_in && !s.pready;
    if (psel_in && penable_in && !s.pready) begin
      next_s.prdata = pwrite_in ? 32'h0 : rd;
      next_s.pslverr = !hit;
    end
    wr = psel_in && penable_in && s.pready && pwrite_in && !s.pslverr;
    if (wr) begin
      unique case (paddr_in)
        REG_MODE: begin
          next_s.alm_comp_on = pwdata_in[MODE_ALM_COMP_BIT];
          if (pwdata_in[MODE_LOC_LSB+:2] <= 2'(CBUS_LOC_LOCATE))
            next_s.loc_mode = cbus_loc_mode_t'(pwdata_in[MODE_LOC_LSB+:2]);
          if (pwdata_in[MODE_SEL_LSB+:2] <= 2'(CBUS_SEL_DERIVED))
            next_s.sel = cbus_sel_t'(pwdata_in[MODE_SEL_LSB+:2]);
        end
        REG_CMD: begin
          capture = pwdata_in[CMD_CAPTURE_BIT];
          clear = pwdata_in[CMD_CLEAR_BIT];
        end
        REG_ALM_PICKUP, REG_LOC_PICKUP: begin
          // out-of-range settings are dropped, old value kept
          if (pwdata_in[31:11] == '0 && pwdata_in[10:0] >= PICKUP_MIN
              && pwdata_in[10:0] <= PICKUP_MAX)
            next_s.pickup[paddr_in[2]] = pwdata_in[10:0];
        end
        REG_ALM_TIME, REG_LOC_TIME: begin
          if (pwdata_in[31:15] == '0 && pwdata_in[14:0] >= TIME_MIN
              && pwdata_in[14:0] <= TIME_MAX)
            next_s.optime[paddr_in[2]] = pwdata_in[14:0];
        end
        REG_ALLOWED: next_s.allowed = pwdata_in[7:0];
        REG_EVENT_EN: next_s.ev_en = pwdata_in[7:0];
        default: next_s.allowed = s.allowed;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      locate = (i == 1) && (s.loc_mode == CBUS_LOC_LOCATE);
      m = mag_approx(comp_re[i], comp_im[i]);
      // percent of set time by repeated subtraction, one step a cycle
      next_s.rem[i] = s.rem[i];
      if (s.rem[i] >= 16'(s.optime[i])) begin
        next_s.rem[i] = 16'(s.rem[i] - 16'(s.optime[i]));
        next_s.pct[i] = 16'(s.pct[i] + 16'h1);
      end
      if (s.start[i] && s.tick10) begin
        next_s.acc[i] = 15'(s.acc[i] + 15'h1);
        next_s.rem[i] = 16'(next_s.rem[i] + PCT_FULL);
      end
      if (s.start[i]) begin
        if (m > s.fit[i]) next_s.fit[i] = m;
        next_s.elapsed_operate_percent[i] = (s.pct[i] > 16'h00ff) ? 8'hff : s.pct[i][7:0];
      end
      if (meas_tick_in && pick[i] && !s.start[i]) begin
        next_s.start[i] = 1'b1;
        next_s.scnt[i] = 16'(s.scnt[i] + 16'h1);
        next_s.acc[i] = '0;
        next_s.rem[i] = '0;
        next_s.pct[i] = '0;
        next_s.fit[i] = '0;
        next_s.events[4*i] = s.ev_en[i][0];
      end else if (meas_tick_in && !pick[i] && s.start[i]) begin
        next_s.start[i] = 1'b0;
        next_s.events[4*i+1] = s.ev_en[i][1];
        if (s.trip[i] && !locate) begin
          next_s.trip[i] = 1'b0;
          next_s.events[4*i+3] = s.ev_en[i][3];
        end
      end
      if (s.start[i] && s.acc[i] >= s.optime[i]) begin
        if (!locate && !s.trip[i]) begin
          next_s.trip[i] = 1'b1;
          next_s.tcnt[i] = 16'(s.tcnt[i] + 16'h1);
          next_s.events[4*i+2] = s.ev_en[i][2];
        end else if (locate) begin
          // confirmed element failure: only the locating reference moves
          next_s.ref_re[1] = rel_re;
          next_s.ref_im[1] = rel_im;
          next_s.chg_re = comp_re[1];
          next_s.chg_im = comp_im[1];
          idx = SECTOR_TO_COUNTER[sector];
          next_s.branch_cnt[idx] = 8'(s.branch_cnt[idx] + 8'h1);
          next_s.total = 8'(s.total + 8'h1);
          next_s.start[1] = 1'b0;
          next_s.acc[1] = '0;
          next_s.events[5] = s.ev_en[1][1];
          if (8'(s.total + 8'h1) > s.allowed && !s.trip[1]) begin
            next_s.trip[1] = 1'b1;
            next_s.tcnt[1] = 16'(s.tcnt[1] + 16'h1);
            next_s.events[6] = s.ev_en[1][2];
          end
        end
      end
    end
    if (capture) begin
      // only software ever captures the natural unbalance
      next_s.ref_re = {rel_re, rel_re};
      next_s.ref_im = {rel_im, rel_im};
      next_s.start = '0;
      next_s.acc = '0;
      if (!(s.loc_mode == CBUS_LOC_LOCATE)) next_s.trip[1] = 1'b0;
      next_s.trip[0] = 1'b0;
    end
    if (clear) begin
      next_s.branch_cnt = '0;
      next_s.total = '0;
      if (s.loc_mode == CBUS_LOC_LOCATE && s.trip[1]) begin
        next_s.trip[1] = 1'b0;
        next_s.events[7] = s.ev_en[1][3];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s <= '0;
      s.loc_mode <= CBUS_LOC_OFF;
      s.sel <= CBUS_SEL_TWO;
      s.pickup <= {LOC_PICKUP_RST, ALM_PICKUP_RST};
      s.optime <= {LOC_TIME_RST, ALM_TIME_RST};
      s.allowed <= ALLOWED_RST;
      s.ev_en <= {EVENT_EN_RST, EVENT_EN_RST};
    end else begin
      s <= next_s;
    end
  end

  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign alarm_start_out = s.start[0];
  assign alarm_trip_out = s.trip[0];
  assign loc_start_out = s.start[1];
  assign loc_trip_out = s.trip[1];
  assign event_out = s.events;

endmodule

// ==== test/cbus_stage_asserts.sv ====
// port-level assertions for the capacitor bank unbalance stage
`timescale 1ns/10ps
module cbus_stage_asserts
  import cbus_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        meas_tick_in,
  input wire logic        alarm_start_out,
  input wire logic        alarm_trip_out,
  input wire logic        loc_start_out,
  input wire logic        loc_trip_out,
  input wire logic [7:0]  event_out
);
  logic cap_wr;
  // capture lands at the completing edge, start may drop one edge later
  assign cap_wr = pready_out && pwrite_in && paddr_in == REG_CMD && pwdata_in[CMD_CAPTURE_BIT];
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  a_one_wait_state: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready late");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_slverr_decode: assert property (pready_out |->
    pslverr_out == (paddr_in > REG_LAST || paddr_in[1:0] != 2'h0)) else $error("pslverr wrong");
  a_alarm_start_tick: assert property ($rose(alarm_start_out) |-> $past(meas_tick_in))
    else $error("alarm start rose without tick");
  a_loc_start_tick: assert property ($rose(loc_start_out) |-> $past(meas_tick_in))
    else $error("locating start rose without tick");
  a_trip_needs_start: assert property ($rose(alarm_trip_out) |->
    alarm_start_out && $past(alarm_start_out)) else $error("alarm trip without start");
  a_start_drop_cause: assert property ($fell(alarm_start_out) |->
    $past(meas_tick_in) || $past(cap_wr) || $past(cap_wr, 2)) else $error("start fell alone");
  a_start_on_event: assert property (event_out[0] |-> $rose(alarm_start_out))
    else $error("start event without start");
  a_loc_off_event: assert property (event_out[5] |-> $fell(loc_start_out))
    else $error("start off event without fall");
  a_loc_trip_event: assert property (event_out[6] |-> $rose(loc_trip_out))
    else $error("trip event without trip");
endmodule
bind cbus_stage cbus_stage_asserts u_chk (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .meas_tick_in(meas_tick_in),
  .alarm_start_out(alarm_start_out), .alarm_trip_out(alarm_trip_out),
  .loc_start_out(loc_start_out), .loc_trip_out(loc_trip_out), .event_out(event_out));

// ==== test/tb.sv ====
// self-checking bench for the capacitor bank unbalance stage
`timescale 1ns/10ps
module tb
  import cbus_pkg::*;
;
  logic               clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, tick = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic signed [15:0] r2re = 16'sh0, r2im = 16'sh0, lcos = 16'sh7fff, lsin = 16'sh0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, err, a_st, a_tr, l_st, l_tr;
  logic [7:0]         ev;
  int                 miscompares = 0, tests_run = 0, ph = 0;
  int                 evc [8] = '{default: 0};
  // input one and the derived sum are large so a wrong selection starts both stages at once
  cbus_stage #(.TIME_BASE_CYCLES_P(4)) u_dut (
    .core_clk_in(clk), .srst_in(srst), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .meas_tick_in(tick), .residual_input_one_re_in(16'sh2000),
    .residual_input_one_im_in(16'sh1000), .residual_input_two_re_in(r2re),
    .residual_input_two_im_in(r2im), .derived_residual_sum_re_in(16'sh2000),
    .derived_residual_sum_im_in(16'sh1000), .l1_cos_in(lcos), .l1_sin_in(lsin),
    .alarm_start_out(a_st), .alarm_trip_out(a_tr), .loc_start_out(l_st), .loc_trip_out(l_tr),
    .event_out(ev));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    ph <= (ph + 1) % 4;
    tick <= (ph == 3);
    for (int i = 0; i < 8; i++) if (ev[i]) evc[i] <= evc[i] + 1;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // phasor readback allows a few lsb of rotation rounding
  task automatic near(input logic [7:0] a, input int er, input int ei);
    int dr, di;
    apb(1'b0, a, 32'h0);
    dr = int'($signed(rd[15:0])) - er;
    di = int'($signed(rd[31:16])) - ei;
    tests_run++;
    if (dr > 3 || dr < -3 || di > 3 || di < -3) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, rd, {16'(ei), 16'(er)});
    end
  endtask
  task automatic waitv(input int s, input logic v, output int n);
    logic cur;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      cur = (s == 0) ? a_st : (s == 1) ? a_tr : (s == 2) ? l_st : l_tr;
    end while (cur !== v && n < 200);
    if (n >= 200) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic t_resets();
    logic [7:0]  ad [8] = '{REG_MODE, REG_ALM_PICKUP, REG_LOC_PICKUP, REG_ALM_TIME,
                            REG_LOC_TIME, REG_ALLOWED, REG_EVENT_EN, REG_STATUS};
    logic [31:0] ex [8] = '{32'h100, 32'h0a, 32'h14, 32'h32, 32'h64, 32'h03, 32'hff, 32'h0};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk(rd, ex[i]);
    end
    apb(1'b1, REG_ALM_PICKUP, 32'h0);
    apb(1'b1, REG_LOC_TIME, 32'h7);
    apb(1'b0, REG_ALM_PICKUP, 32'h0);
    chk(rd, 32'h0a);
    apb(1'b0, REG_LOC_TIME, 32'h0);
    chk(rd, 32'h64);
    apb(1'b1, 8'h60, 32'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, REG_MODE, 32'h300);
    apb(1'b0, REG_MODE, 32'h0);
    chk(rd, 32'h100);
    $display("done reset values");
  endtask
  task automatic t_alarm();
    int n;
    apb(1'b1, REG_ALM_TIME, 32'h8);
    r2re <= 16'sh00c8;
    waitv(0, 1'b1, n);
    waitv(1, 1'b1, n);
    chk({31'h0, n >= 28 && n <= 40}, 32'h1);
    apb(1'b0, REG_ALM_FAULT, 32'h0);
    chk({31'h0, rd[16:0] >= 17'h0c5 && rd[16:0] <= 17'h0c9 && rd[31:24] != 8'h00}, 32'h1);
    near(REG_RAW, 200, 0);
    r2re <= 16'sh0;
    waitv(0, 1'b0, n);
    chk({31'h0, a_tr}, 32'h0);
    apb(1'b0, REG_ALM_COUNTS, 32'h0);
    chk(rd, 32'h00010001);
    chk(32'(evc[0] * 4096 + evc[1] * 256 + evc[2] * 16 + evc[3]), 32'h1111);
    apb(1'b1, REG_EVENT_EN, 32'hf0);
    r2re <= 16'sh00c8;
    waitv(0, 1'b1, n);
    chk(32'(evc[0]), 32'h1);
    r2re <= 16'sh0;
    waitv(0, 1'b0, n);
    apb(1'b1, REG_EVENT_EN, 32'hff);
    $display("done alarm stage");
  endtask
  task automatic t_capture();
    int n;
    apb(1'b1, REG_MODE, 32'h101);
    r2re <= 16'sh012c;
    waitv(0, 1'b1, n);
    apb(1'b1, REG_CMD, 32'h1);
    waitv(0, 1'b0, n);
    chk({31'h0, n <= 2}, 32'h1);
    near(REG_ALM_REF, 300, 0);
    near(REG_ALM_COMP, 0, 0);
    lcos <= 16'sh0;
    lsin <= 16'sh7fff;
    r2re <= 16'sh0;
    r2im <= 16'sh012c;
    repeat (40) @(posedge clk);
    chk({31'h0, a_st}, 32'h0);
    r2im <= 16'sh01f4;
    waitv(1, 1'b1, n);
    near(REG_ALM_COMP, 200, 0);
    lcos <= 16'sh7fff;
    lsin <= 16'sh0;
    r2re <= 16'sh012c;
    r2im <= 16'sh0;
    waitv(0, 1'b0, n);
    $display("done capture");
  endtask
  task automatic t_locate();
    int          n, cr = 300, ci = 0;
    int          sr [6] = '{300, 150, -150, -300, -150, 150};
    int          si [6] = '{0, 260, 260, 0, -260, -260};
    int          ix [6] = '{0, 3, 4, 1, 2, 5};
    logic [47:0] ec = 48'h0;
    apb(1'b1, REG_MODE, 32'h111);
    apb(1'b1, REG_LOC_TIME, 32'h8);
    // normal mode trips on time and never counts
    r2re <= 16'sh0258;
    waitv(3, 1'b1, n);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h0);
    r2re <= 16'sh012c;
    waitv(2, 1'b0, n);
    chk({31'h0, l_tr}, 32'h0);
    apb(1'b1, REG_MODE, 32'h121);
    apb(1'b1, REG_ALLOWED, 32'h6);
    apb(1'b1, REG_CMD, 32'h3);
    for (int k = 0; k < 7; k++) begin
      cr += sr[k % 6];
      ci += si[k % 6];
      ec[8 * ix[k % 6] +: 8] += 8'h1;
      r2re <= 16'(cr);
      r2im <= 16'(ci);
      waitv(2, 1'b1, n);
      waitv(2, 1'b0, n);
      chk({31'h0, l_tr}, {31'h0, k == 6});
      near(REG_CHANGE, sr[k % 6], si[k % 6]);
      near(REG_ALM_COMP, cr - 300, ci);
      apb(1'b0, REG_CNT_LOW, 32'h0);
      chk(rd, ec[31:0]);
      apb(1'b0, REG_CNT_HIGH, 32'h0);
      chk(rd, {16'h0, ec[47:32]});
      apb(1'b0, REG_STATUS, 32'h0);
      chk({24'h0, rd[15:8]}, 32'(k + 1));
    end
    near(REG_LOC_COMP, 0, 0);
    apb(1'b1, REG_CMD, 32'h2);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h0);
    apb(1'b0, REG_CNT_LOW, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, l_tr}, 32'h0);
    $display("done locating");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_resets();
    t_alarm();
    t_capture();
    t_locate();
    tally_and_finish();
  end
endmodule
